/* rtl/ite_pkg.sv */
package ite_pkg;

  // Nibble and timer widths
  localparam int NIB_W   = 4;
  localparam int TIMER_W = 8;

  // Field positions in the first interrupt control register
  localparam int EXT0_EN_BIT      = 0;
  localparam int TIMER_ONE_EN_BIT = 2;
  localparam int TIMER_TWO_EN_BIT = 3;

  // Field position in the edge control register
  localparam int PIN_POLARITY_BIT = 2;

  // Reset values
  localparam logic [3:0] CTRL_RESET_VAL   = 4'h0;
  localparam logic [7:0] TIMER_RESET_VAL  = 8'h00;
  localparam logic       FLAG_RESET_VAL   = 1'b0;
  localparam logic       GIE_RESET_VAL    = 1'b0;

  // Operations accepted from the sequencer
  typedef enum logic [4:0] {
    OP_NO_OPERATION       = 5'b00000,
    OP_IRQ_MASK_ALL       = 5'b00001,
    OP_IRQ_UNMASK         = 5'b00010,
    OP_SKIP_ON_EXT0_REQ   = 5'b00011,
    OP_SKIP_ON_PIN_LEVEL  = 5'b00100,
    OP_READ_IRQ_CTRL_1    = 5'b00101,
    OP_WRITE_IRQ_CTRL_1   = 5'b00110,
    OP_READ_IRQ_CTRL_2    = 5'b00111,
    OP_WRITE_IRQ_CTRL_2   = 5'b01000,
    OP_READ_EDGE_CTRL     = 5'b01001,
    OP_WRITE_EDGE_CTRL    = 5'b01010,
    OP_READ_TMR_CTRL_1    = 5'b01011,
    OP_WRITE_TMR_CTRL_1   = 5'b01100,
    OP_READ_TMR_CTRL_2    = 5'b01101,
    OP_WRITE_TMR_CTRL_2   = 5'b01110,
    OP_READ_TMR_CTRL_6    = 5'b01111,
    OP_WRITE_TMR_CTRL_6   = 5'b10000,
    OP_READ_TIMER_ONE     = 5'b10001,
    OP_WRITE_TIMER_ONE    = 5'b10010,
    OP_READ_TIMER_TWO     = 5'b10011,
    OP_WRITE_TIMER_TWO    = 5'b10100,
    OP_WRITE_RELOAD_ONE   = 5'b10101,
    OP_SKIP_ON_TMR1_REQ   = 5'b10110,
    OP_SKIP_ON_TMR2_REQ   = 5'b10111
  } ite_op_type;

  // One instruction issued by the sequencer
  typedef struct packed {
    logic             valid;
    ite_op_type       op;
    logic [3:0]       acc;
    logic [3:0]       b;
  } ite_instr_type;

  // Load of a timer counter
  typedef struct packed {
    logic             load;
    logic [7:0]       value;
  } ite_timer_load_type;

endpackage : ite_pkg

/* rtl/ite_req_flag.sv */
module ite_req_flag
  import ite_pkg::*;
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Control
  input  wire logic set_in,
  input  wire logic clear_in,
  // State
  output logic      flag_out
);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flag_out <= FLAG_RESET_VAL;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule : ite_req_flag

/* rtl/ite_nibble_reg.sv */
module ite_nibble_reg
  import ite_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // Write port
  input  wire logic       write_in,
  input  wire logic [3:0] data_in,
  // Contents
  output logic [3:0]      value_out
);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      value_out <= CTRL_RESET_VAL;
    end else if (write_in) begin
      value_out <= data_in;
    end
  end

endmodule : ite_nibble_reg

/* rtl/ite_irq_timer_exec.sv */
module ite_irq_timer_exec
  import ite_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  // Instruction from the sequencer
  input  wire ite_instr_type      instr_in,
  // Events and pin
  input  wire logic               ext0_event_in,
  input  wire logic               timer_one_event_in,
  input  wire logic               timer_two_event_in,
  input  wire logic               irq_pin_in,
  // Timer counts
  input  wire logic [7:0]         timer_one_count_in,
  input  wire logic [7:0]         timer_two_count_in,
  // Register results
  output logic [3:0]              acc_out,
  output logic                    acc_write_out,
  output logic [3:0]              b_out,
  output logic                    b_write_out,
  // Sequencing
  output logic                    skip_pending_out,
  output logic                    nullified_out,
  // Interrupt state
  output logic                    global_irq_enable_flag_out,
  output logic                    ext0_request_flag_out,
  output logic                    timer_one_req_flag_out,
  output logic                    timer_two_req_flag_out,
  // Control registers
  output logic [3:0]              irq_ctrl_first_out,
  output logic [3:0]              irq_ctrl_second_out,
  output logic [3:0]              irq_edge_ctrl_out,
  output logic [3:0]              timer_ctrl_first_out,
  output logic [3:0]              timer_ctrl_second_out,
  output logic [3:0]              timer_ctrl_sixth_out,
  // Timers
  output ite_timer_load_type      timer_one_load_out,
  output ite_timer_load_type      timer_two_load_out,
  output logic [7:0]              timer_one_reload_out,
  output logic [7:0]              timer_two_reload_out
);

  // Test of a request flag gated by its enable bit
  function automatic logic flag_skip(input logic enable_bit, input logic flag);
    flag_skip = !enable_bit && flag;
  endfunction : flag_skip

  // Pin level test against the polarity bit
  function automatic logic pin_skip(input logic polarity, input logic pin);
    pin_skip = (pin == polarity);
  endfunction : pin_skip

  logic        exec;
  ite_op_type  op;
  logic        skip_nxt;
  logic        clr_ext0;
  logic        clr_t1;
  logic        clr_t2;
  logic [3:0]  acc_nxt;
  logic        acc_we_nxt;
  logic [3:0]  b_nxt;
  logic        b_we_nxt;
  logic        we_v1;
  logic        we_v2;
  logic        we_i1;
  logic        we_w1;
  logic        we_w2;
  logic        we_w6;
  logic        skip_pending_r;

  // Instruction executes only when not nullified by a skip
  assign exec = instr_in.valid && !skip_pending_r;
  assign op   = instr_in.op;

  // Control registers
  ite_nibble_reg u_irq_ctrl_first (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (we_v1),
    .data_in   (instr_in.acc),
    .value_out (irq_ctrl_first_out)
  );

  ite_nibble_reg u_irq_ctrl_second (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (we_v2),
    .data_in   (instr_in.acc),
    .value_out (irq_ctrl_second_out)
  );

  ite_nibble_reg u_irq_edge_ctrl (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (we_i1),
    .data_in   (instr_in.acc),
    .value_out (irq_edge_ctrl_out)
  );

  ite_nibble_reg u_timer_ctrl_first (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (we_w1),
    .data_in   (instr_in.acc),
    .value_out (timer_ctrl_first_out)
  );

  ite_nibble_reg u_timer_ctrl_second (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (we_w2),
    .data_in   (instr_in.acc),
    .value_out (timer_ctrl_second_out)
  );

  ite_nibble_reg u_timer_ctrl_sixth (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (we_w6),
    .data_in   (instr_in.acc),
    .value_out (timer_ctrl_sixth_out)
  );

  // Request flags
  ite_req_flag u_ext0_flag (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .set_in   (ext0_event_in),
    .clear_in (clr_ext0),
    .flag_out (ext0_request_flag_out)
  );

  ite_req_flag u_timer_one_flag (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .set_in   (timer_one_event_in),
    .clear_in (clr_t1),
    .flag_out (timer_one_req_flag_out)
  );

  ite_req_flag u_timer_two_flag (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .set_in   (timer_two_event_in),
    .clear_in (clr_t2),
    .flag_out (timer_two_req_flag_out)
  );

  // Decode
  always_comb begin
    skip_nxt   = 1'b0;
    clr_ext0   = 1'b0;
    clr_t1     = 1'b0;
    clr_t2     = 1'b0;
    acc_nxt    = acc_out;
    acc_we_nxt = 1'b0;
    b_nxt      = b_out;
    b_we_nxt   = 1'b0;
    we_v1      = 1'b0;
    we_v2      = 1'b0;
    we_i1      = 1'b0;
    we_w1      = 1'b0;
    we_w2      = 1'b0;
    we_w6      = 1'b0;
    if (exec) begin
      case (op)
        OP_SKIP_ON_EXT0_REQ: begin
          skip_nxt = flag_skip(irq_ctrl_first_out[EXT0_EN_BIT], ext0_request_flag_out);
          clr_ext0 = skip_nxt;
        end
        OP_SKIP_ON_PIN_LEVEL: begin
          skip_nxt = pin_skip(irq_edge_ctrl_out[PIN_POLARITY_BIT], irq_pin_in);
        end
        OP_SKIP_ON_TMR1_REQ: begin
          skip_nxt = flag_skip(irq_ctrl_first_out[TIMER_ONE_EN_BIT], timer_one_req_flag_out);
          clr_t1   = skip_nxt;
        end
        OP_SKIP_ON_TMR2_REQ: begin
          skip_nxt = flag_skip(irq_ctrl_first_out[TIMER_TWO_EN_BIT], timer_two_req_flag_out);
          clr_t2   = skip_nxt;
        end
        OP_READ_IRQ_CTRL_1: begin
          acc_nxt    = irq_ctrl_first_out;
          acc_we_nxt = 1'b1;
        end
        OP_WRITE_IRQ_CTRL_1: begin
          we_v1 = 1'b1;
        end
        OP_READ_IRQ_CTRL_2: begin
          acc_nxt    = irq_ctrl_second_out;
          acc_we_nxt = 1'b1;
        end
        OP_WRITE_IRQ_CTRL_2: begin
          we_v2 = 1'b1;
        end
        OP_READ_EDGE_CTRL: begin
          acc_nxt    = irq_edge_ctrl_out;
          acc_we_nxt = 1'b1;
        end
        OP_WRITE_EDGE_CTRL: begin
          we_i1 = 1'b1;
        end
        OP_READ_TMR_CTRL_1: begin
          acc_nxt    = timer_ctrl_first_out;
          acc_we_nxt = 1'b1;
        end
        OP_WRITE_TMR_CTRL_1: begin
          we_w1 = 1'b1;
        end
        OP_READ_TMR_CTRL_2: begin
          acc_nxt    = timer_ctrl_second_out;
          acc_we_nxt = 1'b1;
        end
        OP_WRITE_TMR_CTRL_2: begin
          we_w2 = 1'b1;
        end
        OP_READ_TMR_CTRL_6: begin
          acc_nxt    = timer_ctrl_sixth_out;
          acc_we_nxt = 1'b1;
        end
        OP_WRITE_TMR_CTRL_6: begin
          we_w6 = 1'b1;
        end
        OP_READ_TIMER_ONE: begin
          b_nxt      = timer_one_count_in[TIMER_W-1:NIB_W];
          acc_nxt    = timer_one_count_in[NIB_W-1:0];
          b_we_nxt   = 1'b1;
          acc_we_nxt = 1'b1;
        end
        OP_READ_TIMER_TWO: begin
          b_nxt      = timer_two_count_in[TIMER_W-1:NIB_W];
          acc_nxt    = timer_two_count_in[NIB_W-1:0];
          b_we_nxt   = 1'b1;
          acc_we_nxt = 1'b1;
        end
        default: begin
          skip_nxt = 1'b0;
        end
      endcase
    end
  end

  // Skip state and nullify indication
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      skip_pending_r <= 1'b0;
      nullified_out  <= 1'b0;
    end else if (instr_in.valid && skip_pending_r) begin
      skip_pending_r <= 1'b0;
      nullified_out  <= 1'b1;
    end else begin
      skip_pending_r <= skip_pending_r | skip_nxt;
      nullified_out  <= 1'b0;
    end
  end

  assign skip_pending_out = skip_pending_r;

  // Global interrupt enable
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      global_irq_enable_flag_out <= GIE_RESET_VAL;
    end else if (exec && op == OP_IRQ_MASK_ALL) begin
      global_irq_enable_flag_out <= 1'b0;
    end else if (exec && op == OP_IRQ_UNMASK) begin
      global_irq_enable_flag_out <= 1'b1;
    end
  end

  // Accumulator and B results
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      acc_out       <= CTRL_RESET_VAL;
      acc_write_out <= 1'b0;
      b_out         <= CTRL_RESET_VAL;
      b_write_out   <= 1'b0;
    end else begin
      acc_out       <= acc_nxt;
      acc_write_out <= acc_we_nxt;
      b_out         <= b_nxt;
      b_write_out   <= b_we_nxt;
    end
  end

  // Timer one counter load and reload register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      timer_one_load_out   <= '{load: 1'b0, value: TIMER_RESET_VAL};
      timer_one_reload_out <= TIMER_RESET_VAL;
    end else begin
      timer_one_load_out.load <= 1'b0;
      if (exec && op == OP_WRITE_TIMER_ONE) begin
        timer_one_load_out   <= '{load: 1'b1, value: {instr_in.b, instr_in.acc}};
        timer_one_reload_out <= {instr_in.b, instr_in.acc};
      end else if (exec && op == OP_WRITE_RELOAD_ONE) begin
        timer_one_reload_out <= {instr_in.b, instr_in.acc};
      end
    end
  end

  // Timer two counter load and reload register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      timer_two_load_out   <= '{load: 1'b0, value: TIMER_RESET_VAL};
      timer_two_reload_out <= TIMER_RESET_VAL;
    end else begin
      timer_two_load_out.load <= 1'b0;
      if (exec && op == OP_WRITE_TIMER_TWO) begin
        timer_two_load_out   <= '{load: 1'b1, value: {instr_in.b, instr_in.acc}};
        timer_two_reload_out <= {instr_in.b, instr_in.acc};
      end
    end
  end

endmodule : ite_irq_timer_exec

/* tb/ite_irq_timer_exec_chk.sv */
module ite_irq_timer_exec_chk
  import ite_pkg::*;
(
  // Clock and reset
  input wire logic               clock_in,
  input wire logic               reset_in,
  // Inputs watched
  input wire ite_instr_type      instr_in,
  input wire logic               ext0_event_in,
  input wire logic               timer_one_event_in,
  input wire logic               irq_pin_in,
  input wire logic [7:0]         timer_one_count_in,
  // Outputs watched
  input wire logic [3:0]         acc_out,
  input wire logic               acc_write_out,
  input wire logic [3:0]         b_out,
  input wire logic               b_write_out,
  input wire logic               skip_pending_out,
  input wire logic               nullified_out,
  input wire logic               global_irq_enable_flag_out,
  input wire logic               ext0_request_flag_out,
  input wire logic               timer_one_req_flag_out,
  input wire logic [3:0]         irq_ctrl_first_out,
  input wire logic [3:0]         irq_edge_ctrl_out,
  input wire ite_timer_load_type timer_one_load_out,
  input wire logic [7:0]         timer_one_reload_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic       go;
  logic       pol_q;
  logic [7:0] ba_q;
  logic [7:0] cnt_q;
  assign go = instr_in.valid && !skip_pending_out;
  // Operands as they stood at the taking edge
  always_ff @(posedge clock_in) begin
    pol_q <= irq_edge_ctrl_out[PIN_POLARITY_BIT];
    ba_q  <= {instr_in.b, instr_in.acc};
    cnt_q <= timer_one_count_in;
  end
  a_mask_clears_gie: assert property (go && instr_in.op == OP_IRQ_MASK_ALL |=> !global_irq_enable_flag_out)
    else $error("global enable not cleared");
  a_unmask_sets_gie: assert property (go && instr_in.op == OP_IRQ_UNMASK |=> global_irq_enable_flag_out)
    else $error("global enable not set");
  a_ext0_skip_clear: assert property (go && instr_in.op == OP_SKIP_ON_EXT0_REQ && !irq_ctrl_first_out[0]
    && ext0_request_flag_out && !ext0_event_in |=> !ext0_request_flag_out && skip_pending_out)
    else $error("ext0 test did not skip and clear");
  a_ext0_noop_hold: assert property (go && instr_in.op == OP_SKIP_ON_EXT0_REQ && irq_ctrl_first_out[0]
    && !ext0_event_in |=> $stable(ext0_request_flag_out) && !skip_pending_out)
    else $error("ext0 test not a no-op");
  a_pin_skip_level: assert property (go && instr_in.op == OP_SKIP_ON_PIN_LEVEL
    |=> skip_pending_out == ($past(irq_pin_in) == pol_q)) else $error("pin test skip wrong");
  a_tmr1_read_pair: assert property (go && instr_in.op == OP_READ_TIMER_ONE
    |=> acc_write_out && b_write_out && {b_out, acc_out} == cnt_q) else $error("timer one read wrong");
  a_tmr1_write_both: assert property (go && instr_in.op == OP_WRITE_TIMER_ONE |=> timer_one_load_out.load
    && timer_one_load_out.value == ba_q && timer_one_reload_out == ba_q) else $error("timer one write wrong");
  a_reload_only_keep: assert property (go && instr_in.op == OP_WRITE_RELOAD_ONE
    |=> !timer_one_load_out.load && timer_one_reload_out == ba_q) else $error("reload-only write wrong");
  a_tmr1_skip_clear: assert property (go && instr_in.op == OP_SKIP_ON_TMR1_REQ && !irq_ctrl_first_out[2]
    && timer_one_req_flag_out && !timer_one_event_in |=> !timer_one_req_flag_out && skip_pending_out)
    else $error("timer one test did not skip and clear");
  a_skip_nullify: assert property (instr_in.valid && skip_pending_out |=> nullified_out && !skip_pending_out)
    else $error("skipped instruction not nullified");
  a_skip_hold_idle: assert property (!instr_in.valid && skip_pending_out |=> skip_pending_out)
    else $error("skip pending lost while idle");
  c_ext0_skip: cover property (go && instr_in.op == OP_SKIP_ON_EXT0_REQ && ext0_request_flag_out);
  c_nullify: cover property (nullified_out);
  c_tmr1_write: cover property (timer_one_load_out.load);
endmodule : ite_irq_timer_exec_chk

bind ite_irq_timer_exec ite_irq_timer_exec_chk chk_u (.clock_in, .reset_in, .instr_in, .ext0_event_in,
  .timer_one_event_in, .irq_pin_in, .timer_one_count_in, .acc_out, .acc_write_out, .b_out, .b_write_out,
  .skip_pending_out, .nullified_out, .global_irq_enable_flag_out, .ext0_request_flag_out,
  .timer_one_req_flag_out, .irq_ctrl_first_out, .irq_edge_ctrl_out, .timer_one_load_out, .timer_one_reload_out);

/* tb/ite_timer_model.sv */
module ite_timer_model
  import ite_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  // Loads from the block
  input  wire ite_timer_load_type load_one_in,
  input  wire ite_timer_load_type load_two_in,
  input  wire logic [7:0]         reload_one_in,
  input  wire logic [7:0]         reload_two_in,
  // Counts
  output logic [7:0]              count_one_out,
  output logic [7:0]              count_two_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts down and restarts from the reload value at zero
  always_ff @(posedge clock_in) begin
    if (reset_in) count_one_out <= 8'h00;
    else if (load_one_in.load) count_one_out <= load_one_in.value;
    else if (count_one_out == 8'h00) count_one_out <= reload_one_in;
    else count_one_out <= count_one_out - 8'h01;
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) count_two_out <= 8'h00;
    else if (load_two_in.load) count_two_out <= load_two_in.value;
    else if (count_two_out == 8'h00) count_two_out <= reload_two_in;
    else count_two_out <= count_two_out - 8'h01;
  end
endmodule : ite_timer_model

/* tb/irq_timer_instr_exec_tb_top.sv */
module irq_timer_instr_exec_tb_top;
  import ite_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock_in = 0;
  logic               reset_in = 1;
  ite_instr_type      instr = '0;
  logic [2:0]         ev = '0;
  logic               pin = 0;
  logic [7:0]         t1, t2, c1, c2;
  logic [3:0]         acc_o, b_o;
  logic               accw_o, bw_o, skp_o, nul_o, gie_o;
  logic [2:0]         fl_o;
  logic [3:0]         ctl_o [6];
  ite_timer_load_type ld1_o, ld2_o;
  logic [7:0]         rl1_o, rl2_o;
  logic [3:0]         m_ctl [6] = '{default: 4'h0};
  logic [3:0]         m_acc = '0, m_b = '0;
  logic               m_gie = 0, m_skp = 0, m_nul = 0, m_accw = 0, m_bw = 0;
  logic [2:0]         m_f = '0;
  logic [8:0]         m_ld1 = '0, m_ld2 = '0;
  logic [7:0]         m_rl1 = '0, m_rl2 = '0;
  int                 error_cnt = 0;
  int                 num_checks = 0;

  always #5 clock_in = ~clock_in;

  ite_irq_timer_exec dut_u (.clock_in(clock_in), .reset_in(reset_in), .instr_in(instr),
    .ext0_event_in(ev[0]), .timer_one_event_in(ev[1]), .timer_two_event_in(ev[2]), .irq_pin_in(pin),
    .timer_one_count_in(t1), .timer_two_count_in(t2), .acc_out(acc_o), .acc_write_out(accw_o),
    .b_out(b_o), .b_write_out(bw_o), .skip_pending_out(skp_o), .nullified_out(nul_o),
    .global_irq_enable_flag_out(gie_o), .ext0_request_flag_out(fl_o[0]), .timer_one_req_flag_out(fl_o[1]),
    .timer_two_req_flag_out(fl_o[2]), .irq_ctrl_first_out(ctl_o[0]), .irq_ctrl_second_out(ctl_o[1]),
    .irq_edge_ctrl_out(ctl_o[2]), .timer_ctrl_first_out(ctl_o[3]), .timer_ctrl_second_out(ctl_o[4]),
    .timer_ctrl_sixth_out(ctl_o[5]), .timer_one_load_out(ld1_o), .timer_two_load_out(ld2_o),
    .timer_one_reload_out(rl1_o), .timer_two_reload_out(rl2_o));

  ite_timer_model tmr_u (.clock_in(clock_in), .reset_in(reset_in), .load_one_in(ld1_o), .load_two_in(ld2_o),
    .reload_one_in(rl1_o), .reload_two_in(rl2_o), .count_one_out(t1), .count_two_out(t2));

  task print_verdict;
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  task compare_all;
    chk({acc_o, accw_o, b_o, bw_o}, {m_acc, m_accw, m_b, m_bw}, "acc or b");
    chk({skp_o, nul_o, gie_o, fl_o}, {m_skp, m_nul, m_gie, m_f}, "flags");
    for (int i = 0; i < 6; i++) chk(ctl_o[i], m_ctl[i], "control");
    chk({ld1_o.load, ld2_o.load, rl1_o, rl2_o}, {m_ld1[8], m_ld2[8], m_rl1, m_rl2}, "reload");
    if (m_ld1[8]) chk(ld1_o.value, m_ld1[7:0], "load one");
    if (m_ld2[8]) chk(ld2_o.value, m_ld2[7:0], "load two");
  endtask : compare_all

  // Reference behaviour of one cycle
  task model;
    logic [2:0] clr;
    int         k;
    clr = '0;
    k = (int'(instr.op) - 5) >>> 1;
    {m_accw, m_bw, m_nul, m_ld1[8], m_ld2[8]} = '0;
    if (instr.valid && m_skp) begin
      m_skp = 0;
      m_nul = 1;
    end else if (instr.valid) case (instr.op)
      OP_IRQ_MASK_ALL: m_gie = 0;
      OP_IRQ_UNMASK: m_gie = 1;
      OP_SKIP_ON_EXT0_REQ: if (!m_ctl[0][EXT0_EN_BIT] && m_f[0]) {m_skp, clr[0]} = 2'h3;
      OP_SKIP_ON_TMR1_REQ: if (!m_ctl[0][TIMER_ONE_EN_BIT] && m_f[1]) {m_skp, clr[1]} = 2'h3;
      OP_SKIP_ON_TMR2_REQ: if (!m_ctl[0][TIMER_TWO_EN_BIT] && m_f[2]) {m_skp, clr[2]} = 2'h3;
      OP_SKIP_ON_PIN_LEVEL: m_skp = (pin == m_ctl[2][PIN_POLARITY_BIT]);
      OP_READ_TIMER_ONE: {m_b, m_acc, m_accw, m_bw} = {c1, 2'h3};
      OP_READ_TIMER_TWO: {m_b, m_acc, m_accw, m_bw} = {c2, 2'h3};
      OP_WRITE_TIMER_ONE: {m_ld1, m_rl1} = {1'b1, instr.b, instr.acc, instr.b, instr.acc};
      OP_WRITE_TIMER_TWO: {m_ld2, m_rl2} = {1'b1, instr.b, instr.acc, instr.b, instr.acc};
      OP_WRITE_RELOAD_ONE: m_rl1 = {instr.b, instr.acc};
      default: if (instr.op >= OP_READ_IRQ_CTRL_1 && instr.op <= OP_WRITE_TMR_CTRL_6) begin
        if (instr.op[0]) {m_acc, m_accw} = {m_ctl[k], 1'b1};
        else m_ctl[k] = instr.acc;
      end
    endcase
    m_f = ev | (m_f & ~clr);
  endtask : model

  // Issues one cycle, checks the previous one, then predicts this one
  task step(input logic v, input ite_op_type op, input logic [3:0] a, input logic [2:0] e);
    instr <= '{v, op, a, 4'($urandom)};
    pin <= 1'($urandom);
    ev <= e;
    #1;
    compare_all;
    c1 = t1;
    c2 = t2;
    model;
    @(posedge clock_in);
  endtask : step

  initial begin
    void'($urandom(32'h0de1));
    repeat (3) @(posedge clock_in);
    reset_in <= 0;
    for (int e = 0; e < 2; e++) begin
      step(1, OP_WRITE_IRQ_CTRL_1, e ? 4'hd : 4'h0, 3'h0);
      step(0, OP_NO_OPERATION, 4'h0, 3'h7);
      step(1, OP_SKIP_ON_EXT0_REQ, 4'h0, 3'h0);
      step(1, OP_WRITE_TIMER_ONE, 4'h3, 3'h0);
      step(1, OP_SKIP_ON_EXT0_REQ, 4'h0, 3'h0);
      step(1, OP_SKIP_ON_TMR1_REQ, 4'h0, 3'h0);
      step(1, OP_READ_TIMER_ONE, 4'h0, 3'h0);
      step(1, OP_SKIP_ON_TMR2_REQ, 4'h0, 3'h0);
      step(1, OP_READ_IRQ_CTRL_1, 4'h0, 3'h0);
      step(1, OP_READ_IRQ_CTRL_1, 4'h0, 3'h0);
    end
    repeat (800) step($urandom_range(0, 3) != 0, ite_op_type'($urandom_range(0, 23)), 4'($urandom),
      3'($urandom) & 3'($urandom));
    step(0, OP_NO_OPERATION, 4'h0, 3'h0);
    print_verdict;
  end

  initial begin
    #20000;
    error_cnt++;
    print_verdict;
  end
endmodule : irq_timer_instr_exec_tb_top
